// ### ctsp_pkg.sv
// ctsp_pkg: constants, settings map and carriers of the ct supervision pick-up
package ctsp_pkg;

   localparam int MAG_W = 16;   // magnitudes, 0.01 x nominal per lsb
   localparam int ANG_W = 18;   // signed angles, 0.01 deg per lsb
   localparam int AW    = 8;

   localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
   localparam logic [AW-1:0] OFS_HIGH  = 8'h04;
   localparam logic [AW-1:0] OFS_LOW   = 8'h08;
   localparam logic [AW-1:0] OFS_RATIO = 8'h0C;
   localparam logic [AW-1:0] OFS_SEQ   = 8'h10;
   localparam logic [AW-1:0] OFS_SUMD  = 8'h14;
   localparam logic [AW-1:0] OFS_DELAY = 8'h18;
   localparam logic [AW-1:0] OFS_STAT  = 8'h1C;
   localparam logic [AW-1:0] OFS_MAGD  = 8'h20;
   localparam logic [AW-1:0] OFS_ANGD  = 8'h24;
   localparam logic [AW-1:0] OFS_NATA  = 8'h28;
   localparam logic [AW-1:0] OFS_CNT   = 8'h2C;

   localparam logic [MAG_W-1:0] RST_HIGH  = 16'h0078; // 1.20 x nominal
   localparam logic [MAG_W-1:0] RST_LOW   = 16'h000A; // 0.10 x nominal
   localparam logic [MAG_W-1:0] RST_RATIO = 16'h03E8; // 10.00 %
   localparam logic [MAG_W-1:0] RST_SEQ   = 16'h1324; // 49.00 %
   localparam logic [MAG_W-1:0] RST_SUMD  = 16'h000A; // 0.10 x nominal
   localparam logic [MAG_W-1:0] RST_DELAY = 16'h0064; // 0.5 s in 0.005 s steps

   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_COMP    = 4;

   localparam int ST_ALARM = 0;
   localparam int ST_BLOCK = 1;
   localparam int ST_START = 2;
   localparam int ST_PICK  = 3;
   localparam int ST_CONDS = 4;

   localparam int PCT_FULL       = 100;
   localparam int HYS_OVER_PCT   = 97;
   localparam int HYS_UNDER_PCT  = 103;
   localparam int RATIO_FULL     = 10000; // 100.00 %
   localparam int DELAY_STEP_US  = 5000;
   localparam int MEAS_PERIOD_US = 5000;
   localparam int STEPS_PER_MEAS = DELAY_STEP_US / MEAS_PERIOD_US;

   localparam logic signed [ANG_W-1:0] ANG_TURN = 18'sh08CA0; // 360.00 deg

   typedef enum logic [1:0] {
      CTSP_RES_NONE   = 2'h0,
      CTSP_RES_FIRST  = 2'h1,
      CTSP_RES_SECOND = 2'h2
   } ctsp_res_sel_t;

   typedef struct packed {
      logic [2:0][MAG_W-1:0]        phase_mag;
      logic [MAG_W-1:0]             pos_seq;
      logic [MAG_W-1:0]             neg_seq;
      logic [1:0][MAG_W-1:0]        res_mag;
      logic [1:0][ANG_W-1:0]        res_ang;
      logic [MAG_W-1:0]             sum_mag;
      logic signed [ANG_W-1:0]      sum_ang;
   } ctsp_meas_t;

endpackage

// ### ctsp_hyst.sv
// ctsp_hyst: threshold comparator with built-in release hysteresis
`timescale 1ns/1ps
module ctsp_hyst
   import ctsp_pkg::*;
#(
   parameter bit OVER = 1'b1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             upd,
   input  wire logic [MAG_W-1:0] value,
   input  wire logic [MAG_W-1:0] thr,
   output logic                  hit
);

   logic [MAG_W+7:0] val_pct;
   logic [MAG_W+7:0] rel_pct;
   logic             hit_q;

   // scaled by 100 so the release point needs no divider
   assign val_pct = (MAG_W+8)'(value) * (MAG_W+8)'(PCT_FULL);
   assign rel_pct = (MAG_W+8)'(thr) *
                    (OVER ? (MAG_W+8)'(HYS_OVER_PCT) : (MAG_W+8)'(HYS_UNDER_PCT));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hit_q <= 1'b0;
      end else if (upd) begin
         if (OVER) begin
            hit_q <= hit_q ? !(val_pct < rel_pct) : (value > thr);
         end else begin
            hit_q <= hit_q ? !(val_pct > rel_pct) : (value < thr);
         end
      end
   end

   assign hit = hit_q;

endmodule

// ### ctsp_top.sv
// ctsp_top: ct supervision pick-up, alarm delay and apb settings
//
// Overview of operation
// - release hysteresis 97 % over, 103 % under
// - every phase and residual scaled against threshold
// - one threshold; any phase above triggers
// - phase above high limit inhibits alarm
// - some phase must exceed low limit
// - min/max phase ratio below ratio setting
// - negative/positive sequence ratio above setting
// - single phase loss gives 50 % ratio
// - residual difference above setting when selected
// - definite alarm delay in 0.005 s steps
// - start only when pick-up and not blocked
// - binary pick-up input acts at once
// - readable residual magnitude difference, 0.01 steps
// - readable residual angle difference, 0.01 deg
// - readable compensated natural unbalance angle
// - all conditions held through whole delay
// - block at pick-up: blocked out, start resets
// - residual source: none, first, second input
`timescale 1ns/1ps
module ctsp_top
   import ctsp_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire ctsp_meas_t    meas,
   input  wire logic          meas_valid,
   input  wire logic          block_in,
   input  wire logic          bin_pickup,
   output logic               alarm,
   output logic               blocked,
   output logic               start
);

   typedef enum logic [3:0] {
      CTSP_IDLE  = 4'b0001,
      CTSP_TIME  = 4'b0010,
      CTSP_ALARM = 4'b0100,
      CTSP_BLOCK = 4'b1000
   } ctsp_state_t;

   function automatic logic ctsp_mapped(input logic [AW-1:0] a);
      ctsp_mapped = (a[1:0] == 2'h0) && (a <= OFS_CNT);
   endfunction

   function automatic logic signed [ANG_W-1:0] ctsp_wrap(
      input logic signed [ANG_W-1:0] x);
      if (x > ANG_TURN) begin
         ctsp_wrap = x - ANG_TURN;
      end else if (x < -ANG_TURN) begin
         ctsp_wrap = x + ANG_TURN;
      end else begin
         ctsp_wrap = x;
      end
   endfunction

   ctsp_state_t             state_q;
   ctsp_state_t             state_d;
   ctsp_res_sel_t           sel_q;
   logic [MAG_W-1:0]        high_q;
   logic [MAG_W-1:0]        low_q;
   logic [MAG_W-1:0]        ratio_q;
   logic [MAG_W-1:0]        seq_q;
   logic [MAG_W-1:0]        sumd_q;
   logic [MAG_W-1:0]        delay_q;
   logic [MAG_W-1:0]        cnt_q;
   logic [MAG_W-1:0]        cnt_d;
   logic [MAG_W-1:0]        magd_q;
   logic signed [ANG_W-1:0] angd_q;
   logic signed [ANG_W-1:0] comp_q;
   logic signed [ANG_W-1:0] nata_q;
   logic [31:0]             prdata_q;
   logic                    ratio_ok_q;
   logic                    seq_ok_q;
   logic [2:0]              lo_hit;
   logic [2:0]              hi_hit;
   logic [2:0]              un_hit;
   logic                    res_hit;
   logic [MAG_W-1:0]        ph_min;
   logic [MAG_W-1:0]        ph_max;
   logic [MAG_W-1:0]        res_mag;
   logic signed [ANG_W-1:0] res_ang;
   logic [MAG_W-1:0]        magd;
   logic signed [ANG_W-1:0] angd;
   logic                    conds_ok;
   logic                    pickup;
   logic                    wr_en;
   logic                    rd_setup;
   logic                    comp_req;
   logic [31:0]             status;

   // apb: zero wait, read data captured in the setup cycle
   assign wr_en    = psel && penable && pwrite && ctsp_mapped(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !ctsp_mapped(paddr);
   assign comp_req = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_COMP];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q   <= CTSP_RES_NONE;
         high_q  <= RST_HIGH;
         low_q   <= RST_LOW;
         ratio_q <= RST_RATIO;
         seq_q   <= RST_SEQ;
         sumd_q  <= RST_SUMD;
         delay_q <= RST_DELAY;
      end else if (wr_en) begin
         unique case (paddr)
            OFS_CTRL: begin
               // code 3 is not a source; keep the old selection
               if (pwdata[CTRL_SEL_LSB+1 -: 2] != 2'h3) begin
                  sel_q <= ctsp_res_sel_t'(pwdata[CTRL_SEL_LSB+1 -: 2]);
               end
            end
            OFS_HIGH:  high_q  <= pwdata[MAG_W-1:0];
            OFS_LOW:   low_q   <= pwdata[MAG_W-1:0];
            OFS_RATIO: ratio_q <= pwdata[MAG_W-1:0];
            OFS_SEQ:   seq_q   <= pwdata[MAG_W-1:0];
            OFS_SUMD:  sumd_q  <= pwdata[MAG_W-1:0];
            OFS_DELAY: delay_q <= pwdata[MAG_W-1:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      status = 32'h0;
      status[ST_ALARM]        = state_q == CTSP_ALARM;
      status[ST_BLOCK]        = state_q == CTSP_BLOCK;
      status[ST_START]        = (state_q == CTSP_TIME) || (state_q == CTSP_ALARM);
      status[ST_PICK]         = pickup;
      status[ST_CONDS]        = conds_ok;
      status[ST_CONDS+1 +: 3] = lo_hit;
      status[ST_CONDS+4 +: 3] = hi_hit;
      status[ST_CONDS+7]      = ratio_ok_q;
      status[ST_CONDS+8]      = seq_ok_q;
      status[ST_CONDS+9]      = res_hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (rd_setup) begin
         case (paddr)
            OFS_CTRL:  prdata_q <= {30'h0, sel_q};
            OFS_HIGH:  prdata_q <= {16'h0, high_q};
            OFS_LOW:   prdata_q <= {16'h0, low_q};
            OFS_RATIO: prdata_q <= {16'h0, ratio_q};
            OFS_SEQ:   prdata_q <= {16'h0, seq_q};
            OFS_SUMD:  prdata_q <= {16'h0, sumd_q};
            OFS_DELAY: prdata_q <= {16'h0, delay_q};
            OFS_STAT:  prdata_q <= status;
            OFS_MAGD:  prdata_q <= {16'h0, magd_q};
            OFS_ANGD:  prdata_q <= 32'(angd_q);
            OFS_NATA:  prdata_q <= 32'(nata_q);
            OFS_CNT:   prdata_q <= {16'h0, cnt_q};
            default:   prdata_q <= 32'h0;
         endcase
      end
   end

   assign prdata = prdata_q;

   // per-phase comparators share one setting per limit
   for (genvar i = 0; i < 3; i++) begin : g_phase
      ctsp_hyst #(.OVER(1'b1)) u_lo (
         .pclk    (pclk),
         .presetn (presetn),
         .upd     (meas_valid),
         .value   (meas.phase_mag[i]),
         .thr     (low_q),
         .hit     (lo_hit[i])
      );
      ctsp_hyst #(.OVER(1'b1)) u_hi (
         .pclk    (pclk),
         .presetn (presetn),
         .upd     (meas_valid),
         .value   (meas.phase_mag[i]),
         .thr     (high_q),
         .hit     (hi_hit[i])
      );
      ctsp_hyst #(.OVER(1'b0)) u_un (
         .pclk    (pclk),
         .presetn (presetn),
         .upd     (meas_valid),
         .value   (meas.phase_mag[i]),
         .thr     (low_q),
         .hit     (un_hit[i])
      );
   end

   always_comb begin
      ph_min = meas.phase_mag[0];
      ph_max = meas.phase_mag[0];
      for (int k = 1; k < 3; k++) begin
         if (meas.phase_mag[k] < ph_min) begin
            ph_min = meas.phase_mag[k];
         end
         if (meas.phase_mag[k] > ph_max) begin
            ph_max = meas.phase_mag[k];
         end
      end
   end

   // residual source picks magnitude and angle
   always_comb begin
      unique case (sel_q)
         CTSP_RES_FIRST: begin
            res_mag = meas.res_mag[0];
            res_ang = meas.res_ang[0];
         end
         CTSP_RES_SECOND: begin
            res_mag = meas.res_mag[1];
            res_ang = meas.res_ang[1];
         end
         default: begin
            res_mag = '0;
            res_ang = '0;
         end
      endcase
   end

   assign magd = (meas.sum_mag > res_mag) ? meas.sum_mag - res_mag
                                          : res_mag - meas.sum_mag;
   assign angd = ctsp_wrap(meas.sum_ang - res_ang);

   ctsp_hyst #(.OVER(1'b1)) u_res (
      .pclk    (pclk),
      .presetn (presetn),
      .upd     (meas_valid),
      .value   (magd),
      .thr     (sumd_q),
      .hit     (res_hit)
   );

   // ratios compared by cross products, no divider needed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_ok_q <= 1'b0;
         seq_ok_q   <= 1'b0;
      end else if (meas_valid) begin
         ratio_ok_q <= 32'(ph_min) * 32'(RATIO_FULL) <
                       32'(ratio_q) * 32'(ph_max);
         // ratio is plain negative over positive sequence
         seq_ok_q   <= 32'(meas.neg_seq) * 32'(RATIO_FULL) >
                       32'(seq_q) * 32'(meas.pos_seq);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         magd_q <= '0;
         angd_q <= '0;
         nata_q <= '0;
      end else if (meas_valid) begin
         magd_q <= magd;
         angd_q <= angd;
         nata_q <= ctsp_wrap(angd - comp_q);
      end
   end

   // compensation freezes the present angle offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_q <= '0;
      end else if (comp_req) begin
         comp_q <= angd_q;
      end
   end

   assign conds_ok = !(|hi_hit) && (|lo_hit) && (|un_hit) && ratio_ok_q && seq_ok_q &&
                     ((sel_q == CTSP_RES_NONE) || res_hit);

   // binary pick-up bypasses the measurement cycle
   assign pickup = conds_ok || bin_pickup;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         CTSP_IDLE: begin
            cnt_d = '0;
            if (pickup) begin
               state_d = block_in ? CTSP_BLOCK : CTSP_TIME;
            end
         end
         CTSP_TIME: begin
            if (!pickup) begin
               state_d = CTSP_IDLE;
               cnt_d   = '0;
            end else if (block_in) begin
               state_d = CTSP_BLOCK;
               cnt_d   = '0;
            end else if (cnt_q >= delay_q) begin
               state_d = CTSP_ALARM;
            end else if (meas_valid) begin
               cnt_d = cnt_q + MAG_W'(STEPS_PER_MEAS);
            end
         end
         CTSP_ALARM: begin
            if (!pickup) begin
               state_d = CTSP_IDLE;
            end else if (block_in) begin
               state_d = CTSP_BLOCK;
            end
         end
         CTSP_BLOCK: begin
            cnt_d = '0;
            if (!pickup) begin
               state_d = CTSP_IDLE;
            end else if (!block_in) begin
               state_d = CTSP_TIME;
            end
         end
         default: begin
            state_d = CTSP_IDLE;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CTSP_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // outputs straight from one-hot state flops
   assign start   = state_q[1] || state_q[2];
   assign alarm   = state_q[2];
   assign blocked = state_q[3];

endmodule

// ### ctsp_assertions.sv
// ctsp_assertions: port-level checks of the ct supervision pick-up
`timescale 1ns/1ps
module ctsp_chk
   import ctsp_pkg::*;
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic          pready,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire ctsp_meas_t    meas,
   input wire logic          meas_valid,
   input wire logic          block_in,
   input wire logic          bin_pickup,
   input wire logic          alarm,
   input wire logic          blocked,
   input wire logic          start
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [MAG_W-1:0] high_q, low_q, dly_q, mv_q;
   logic             over_hi, under_lo;

   // shadow settings so the limits follow software writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_q <= RST_HIGH;
         low_q  <= RST_LOW;
         dly_q  <= RST_DELAY;
      end else if (psel && penable && pwrite && pready) begin
         if (paddr == OFS_HIGH) high_q <= pwdata[MAG_W-1:0];
         if (paddr == OFS_LOW) low_q <= pwdata[MAG_W-1:0];
         if (paddr == OFS_DELAY) dly_q <= pwdata[MAG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mv_q <= '0;
      end else if (!start) begin
         mv_q <= '0;
      end else if (meas_valid) begin
         mv_q <= mv_q + 1'b1;
      end
   end

   // only clear-cut levels arm the checks, so hysteresis cannot fire them
   always_comb begin
      over_hi  = 1'b0;
      under_lo = 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (meas.phase_mag[i] > high_q) over_hi = 1'b1;
         if (32'(meas.phase_mag[i]) * 100 >= 32'(low_q) * 97) under_lo = 1'b0;
      end
   end

   chk_start_free: assert property ($rose(start) |-> !$past(block_in))
      else $error("start rose while blocking was active");
   chk_block_drop: assert property (start && block_in |=> !start)
      else $error("start held under blocking");
   chk_block_flag: assert property (bin_pickup && block_in && !alarm |=> blocked)
      else $error("blocked missing on blocked pick-up");
   chk_bin_fast: assert property (bin_pickup && !block_in && !start && !blocked && !alarm
      |=> start)
      else $error("binary pick-up did not start at once");
   chk_alarm_delay: assert property ($rose(alarm) |-> mv_q >= dly_q)
      else $error("alarm before delay ran out");
   chk_alarm_start: assert property ($rose(alarm) |-> $past(start))
      else $error("alarm without running start");
   chk_high_stop: assert property (meas_valid && over_hi && !bin_pickup ##1 !bin_pickup
      |=> !start)
      else $error("start above high limit");
   chk_low_need: assert property (meas_valid && under_lo && !bin_pickup ##1 !bin_pickup
      |=> !start)
      else $error("start with all phases below low limit");

   cov_alarm: cover property ($rose(alarm));
   cov_block: cover property ($rose(blocked));
   cov_bin: cover property (bin_pickup && !start ##1 start);
endmodule

// ### ctsp_meas_src.sv
// ctsp_meas_src: measurement front end model, one sample every gap+1 cycles
`timescale 1ns/1ps
module ctsp_meas_src
   import ctsp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire ctsp_meas_t next_meas,
   input  wire logic [7:0] gap,
   output ctsp_meas_t      meas,
   output logic            meas_valid
);
   logic [7:0] cnt_q;
   // sample lands with its strobe and holds until the next one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q      <= 8'h00;
         meas       <= '0;
         meas_valid <= 1'b0;
      end else begin
         meas_valid <= (cnt_q == gap);
         cnt_q      <= (cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
         if (cnt_q == gap) meas <= next_meas;
      end
   end
endmodule

// ### ct_supervision_pickup_tb_top.sv
// ct_supervision_pickup_tb_top: directed bench, apb master and measurement feed
`timescale 1ns/1ps
module ct_supervision_pickup_tb_top;
   import ctsp_pkg::*;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [AW-1:0] paddr = '0;
   logic [31:0]   pwdata = '0;
   logic [31:0]   prdata, rd;
   logic          pready, pslverr, perr, meas_valid, alarm, blocked, start;
   logic          block_in = 1'b0;
   logic          bin_pickup = 1'b0;
   logic [7:0]    gap = 8'h04;
   ctsp_meas_t    meas;
   ctsp_meas_t    next_meas = '0;
   int            fails = 0;
   int            check_count = 0;

   always #25 pclk = ~pclk;

   ctsp_top ctsp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .meas, .meas_valid, .block_in, .bin_pickup, .alarm,
      .blocked, .start);
   ctsp_meas_src ctsp_meas_src_i (.pclk, .presetn, .next_meas, .gap, .meas, .meas_valid);

   function automatic ctsp_meas_t mk(input int a, b, c, p, g, r);
      ctsp_meas_t m;
      m = '0;
      m.phase_mag[0] = MAG_W'(a);
      m.phase_mag[1] = MAG_W'(b);
      m.phase_mag[2] = MAG_W'(c);
      m.pos_seq = MAG_W'(p);
      m.neg_seq = MAG_W'(g);
      m.sum_mag = 16'h0064;
      m.res_mag[0] = MAG_W'(r);
      return m;
   endfunction

   task automatic cmp(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // apb master: request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) fails++;
      rd      = prdata;
      perr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // first strobe may carry the old sample, so two are awaited
   task automatic exp_start(input ctsp_meas_t m, input logic e);
      next_meas <= m;
      repeat (2) @(posedge meas_valid);
      repeat (3) @(posedge pclk);
      cmp({31'h0, start}, {31'h0, e});
   endtask

   task automatic t_regs();
      logic [AW-1:0] a [6];
      logic [15:0]   v [6];
      a = '{OFS_HIGH, OFS_LOW, OFS_RATIO, OFS_SEQ, OFS_SUMD, OFS_DELAY};
      v = '{RST_HIGH, RST_LOW, RST_RATIO, RST_SEQ, RST_SUMD, RST_DELAY};
      cmp({29'h0, alarm, blocked, start}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, a[i], 32'h0);
         cmp(rd, {16'h0, v[i]});
      end
      apb(1'b0, 8'h30, 32'h0);
      cmp({perr, rd[30:0]}, 32'h80000000);
      apb(1'b1, OFS_DELAY, 32'h3);
      apb(1'b0, OFS_DELAY, 32'h0);
      cmp(rd, 32'h3);
   endtask

   task automatic t_fault();
      int n;
      n = 0;
      next_meas <= mk(100, 100, 0, 67, 33, 100);
      for (int k = 0; k < 100 && start !== 1'b1; k++) @(posedge pclk);
      for (int k = 0; k < 200 && alarm !== 1'b1; k++) begin
         @(posedge pclk);
         n += meas_valid;
      end
      cmp(32'(n), 32'h3);
      exp_start(mk(100, 100, 100, 100, 0, 100), 1'b0);
      cmp({31'h0, alarm}, 32'h0);
      exp_start(mk(100, 100, 0, 67, 33, 100), 1'b1);
      cmp({31'h0, alarm}, 32'h0);
      exp_start(mk(100, 100, 100, 100, 0, 100), 1'b0);
   endtask

   task automatic t_reject();
      exp_start(mk(130, 100, 0, 77, 40, 100), 1'b0);
      exp_start(mk(118, 100, 0, 77, 40, 100), 1'b0);
      exp_start(mk(110, 100, 0, 77, 40, 100), 1'b1);
      exp_start(mk(9, 9, 0, 6, 3, 100), 1'b0);
      exp_start(mk(100, 0, 0, 33, 33, 100), 1'b1);
      exp_start(mk(100, 100, 0, 80, 20, 100), 1'b0);
      apb(1'b1, OFS_LOW, 32'h32);
      exp_start(mk(100, 100, 20, 60, 40, 100), 1'b0);
      exp_start(mk(100, 100, 4, 60, 40, 100), 1'b1);
      apb(1'b1, OFS_LOW, 32'h0A);
      exp_start(mk(100, 100, 100, 100, 0, 100), 1'b0);
   endtask

   task automatic t_resid();
      ctsp_meas_t m;
      m = mk(100, 100, 0, 67, 33, 100);
      m.sum_ang = 18'sh00C00;
      gap <= 8'h09;
      apb(1'b1, OFS_CTRL, 32'h1);
      exp_start(m, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h2);
      exp_start(m, 1'b1);
      apb(1'b0, OFS_MAGD, 32'h0);
      cmp(rd, 32'h64);
      apb(1'b0, OFS_ANGD, 32'h0);
      cmp(rd, 32'hC00);
      apb(1'b0, OFS_NATA, 32'h0);
      cmp(rd, 32'hC00);
      // compensation takes effect from the next sample on
      apb(1'b1, OFS_CTRL, 32'h12);
      repeat (2) @(posedge meas_valid);
      @(posedge pclk);
      apb(1'b0, OFS_NATA, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b0, OFS_CTRL, 32'h0);
      cmp(rd, 32'h2);
      apb(1'b1, OFS_CTRL, 32'h0);
      exp_start(mk(100, 100, 100, 100, 0, 100), 1'b0);
   endtask

   task automatic t_block();
      bin_pickup <= 1'b1;
      repeat (2) @(posedge pclk);
      cmp({29'h0, alarm, blocked, start}, 32'h1);
      block_in <= 1'b1;
      repeat (2) @(posedge pclk);
      cmp({29'h0, alarm, blocked, start}, 32'h2);
      block_in <= 1'b0;
      repeat (2) @(posedge pclk);
      cmp({29'h0, alarm, blocked, start}, 32'h1);
      bin_pickup <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_fault();
      t_reject();
      t_resid();
      t_block();
      print_verdict();
   end

   // watchdog: the whole run needs a few hundred cycles
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end
endmodule

bind ctsp_top ctsp_chk ctsp_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
   .meas(meas), .meas_valid(meas_valid), .block_in(block_in), .bin_pickup(bin_pickup),
   .alarm(alarm), .blocked(blocked), .start(start));
